/* File: hw/pllps_top.sv */
`include "pllps_consts.svh"
`default_nettype none

module pllps_top
    import pllps_pkg::*;
#(
    parameter int WAKE_CYCLES = `PLLPS_WAKE_CYCLES,
    parameter int PULSE_LIMIT = `PLLPS_PULSE_LIMIT
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_serial_clock,
    input wire logic i_serial_data,
    input wire logic i_load_strobe,
    input wire logic i_tristate_control_input,
    input wire logic i_power_save_input,
    input wire logic i_pd_up,
    input wire logic i_pd_down,
    input wire logic i_lock_raw,
    output logic o_cp_out,
    output logic o_cp_oe,
    output logic o_lock_indicator,
    output logic o_power_saving,
    output logic [`PLLPS_PAYLOAD_BITS-1:0] o_ref_word,
    output logic [`PLLPS_PAYLOAD_BITS-1:0] o_main_word,
    output logic o_ref_load,
    output logic o_main_load
);

    pllps_link_if link ();

    pllps_serial_shift u_shift (
        .i_serial_clock(i_serial_clock),
        .i_rst_n(i_rst_n),
        .i_serial_data(i_serial_data),
        .i_load_strobe(i_load_strobe),
        .link(link.link)
    );

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [1:0] ps_sync;
    logic [1:0] zc_sync;
    logic [1:0] le_sync;
    logic le_prev;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ps_sync <= 2'h0;
        end else begin
            ps_sync <= {ps_sync[0], i_power_save_input};
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            zc_sync <= 2'h0;
        end else begin
            zc_sync <= {zc_sync[0], i_tristate_control_input};
        end
    end

    // The strobe history resets to its idle high level so that no false rise follows reset.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            le_sync <= 2'h3;
            le_prev <= 1'b1;
        end else begin
            le_sync <= {le_sync[0], i_load_strobe};
            le_prev <= le_sync[1];
        end
    end

    wire ps_high = ps_sync[1];
    wire zc_high = zc_sync[1];
    wire le_rise = le_sync[1] & ~le_prev;

    function automatic logic [`PLLPS_TIMER_BITS-1:0] timer_step(
        input logic [`PLLPS_TIMER_BITS-1:0] value
    );
        return value + 1'b1;
    endfunction : timer_step

    // ------------------------------------------------------------------------
    // Power saving state machine
    // ------------------------------------------------------------------------
    // Reset lands in standby, which matches the power-on level the host holds.
    pllps_state_e state;
    pllps_state_e next_state;
    logic [`PLLPS_TIMER_BITS-1:0] wake_timer;
    logic [`PLLPS_TIMER_BITS-1:0] next_wake_timer;
    wire wake_done = (wake_timer == `PLLPS_TIMER_BITS'(WAKE_CYCLES - 1));

    always_comb begin
        next_state = state;
        next_wake_timer = '0;
        unique case (state)
            PLLPS_STANDBY: begin
                if (ps_high) begin
                    next_state = PLLPS_WAKE;
                end
            end
            PLLPS_WAKE: begin
                next_wake_timer = timer_step(wake_timer);
                if (!ps_high) begin
                    next_state = PLLPS_STANDBY;
                end else if (wake_done) begin
                    next_state = PLLPS_NORMAL;
                end
            end
            PLLPS_NORMAL: begin
                if (!ps_high) begin
                    next_state = PLLPS_STANDBY;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= PLLPS_STANDBY;
            wake_timer <= '0;
        end else begin
            state <= next_state;
            wake_timer <= next_wake_timer;
        end
    end

    wire saving = (state == PLLPS_STANDBY);
    wire waking = (state == PLLPS_WAKE);

    // ------------------------------------------------------------------------
    // Charge pump output with wake-up pulse limiting
    // ------------------------------------------------------------------------
    // While waking, each error pulse is cut after a fixed number of cycles so
    // that an arbitrary divider alignment cannot kick the oscillator far.
    logic [`PLLPS_TIMER_BITS-1:0] pulse_len;
    wire pd_active = i_pd_up ^ i_pd_down;
    wire pulse_cut = waking && (pulse_len >= `PLLPS_TIMER_BITS'(PULSE_LIMIT));
    wire [`PLLPS_TIMER_BITS-1:0] next_pulse_len =
        !pd_active ? '0 : (pulse_cut ? pulse_len : timer_step(pulse_len));

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pulse_len <= '0;
        end else begin
            pulse_len <= next_pulse_len;
        end
    end

    wire pump_allowed = zc_high & ~saving;
    wire next_cp_oe = pump_allowed & pd_active & ~pulse_cut;
    wire next_cp_out = next_cp_oe & i_pd_up;
    wire next_lock = saving | i_lock_raw;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cp_oe <= 1'b0;
            o_cp_out <= 1'b0;
        end else begin
            o_cp_oe <= next_cp_oe;
            o_cp_out <= next_cp_out;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_lock_indicator <= 1'b1;
        end else begin
            o_lock_indicator <= next_lock;
        end
    end

    assign o_power_saving = saving;

    // ------------------------------------------------------------------------
    // Divider latches
    // ------------------------------------------------------------------------
    // The shift word is static while the strobe is high, so it is read only
    // after the synchronised rising edge of the strobe.
    wire word_ok = le_rise & link.word_full;
    wire dest_ref = link.word[`PLLPS_DEST_BIT];
    wire [`PLLPS_PAYLOAD_BITS-1:0] payload =
        link.word[`PLLPS_PAYLOAD_LSB +: `PLLPS_PAYLOAD_BITS];
    wire load_ref = word_ok & dest_ref;
    wire load_main = word_ok & ~dest_ref;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ref_word <= `PLLPS_PAYLOAD_RESET;
            o_ref_load <= 1'b0;
        end else begin
            o_ref_load <= load_ref;
            if (load_ref) begin
                o_ref_word <= payload;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_main_word <= `PLLPS_PAYLOAD_RESET;
            o_main_load <= 1'b0;
        end else begin
            o_main_load <= load_main;
            if (load_main) begin
                o_main_word <= payload;
            end
        end
    end

endmodule : pllps_top

`default_nettype wire

/* File: hw/pllps_consts.svh */
`ifndef PLLPS_CONSTS_SVH
`define PLLPS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Serial word layout
// ----------------------------------------------------------------------------
`define PLLPS_WORD_BITS 19
`define PLLPS_COUNT_BITS 5
`define PLLPS_DEST_BIT 0
`define PLLPS_PAYLOAD_LSB 1
`define PLLPS_PAYLOAD_BITS 18
`define PLLPS_PAYLOAD_RESET 18'h00000

// ----------------------------------------------------------------------------
// Wake-up error limiting
// ----------------------------------------------------------------------------
`define PLLPS_WAKE_CYCLES 256
`define PLLPS_PULSE_LIMIT 2
`define PLLPS_TIMER_BITS 12

`endif

/* File: hw/pllps_pkg.sv */
`default_nettype none

package pllps_pkg;

    typedef enum logic [2:0] {
        PLLPS_STANDBY = 3'b001,
        PLLPS_WAKE = 3'b010,
        PLLPS_NORMAL = 3'b100
    } pllps_state_e;

endpackage : pllps_pkg

`default_nettype wire

/* File: hw/pllps_link_if.sv */
`include "pllps_consts.svh"
`default_nettype none

interface pllps_link_if;
    logic [`PLLPS_WORD_BITS-1:0] word;
    logic word_full;

    modport link (output word, output word_full);
    modport core (input word, input word_full);
endinterface : pllps_link_if

`default_nettype wire

/* File: hw/pllps_serial_shift.sv */
`include "pllps_consts.svh"
`default_nettype none

module pllps_serial_shift (
    input wire logic i_serial_clock,
    input wire logic i_rst_n,
    input wire logic i_serial_data,
    input wire logic i_load_strobe,
    pllps_link_if.link link
);

    logic [`PLLPS_WORD_BITS-1:0] shift;
    logic [`PLLPS_COUNT_BITS-1:0] count;
    logic [`PLLPS_WORD_BITS-1:0] next_shift;
    logic [`PLLPS_COUNT_BITS-1:0] next_count;
    logic full;

    // ------------------------------------------------------------------------
    // Shift path
    // ------------------------------------------------------------------------
    // The first bit shifted ends up in bit 0 once a whole word is in.
    assign full = (count == `PLLPS_COUNT_BITS'(`PLLPS_WORD_BITS));
    assign next_shift = i_load_strobe ? shift : {i_serial_data, shift[`PLLPS_WORD_BITS-1:1]};
    // An edge seen while the strobe is high starts a fresh word count.
    assign next_count = i_load_strobe ? '0 : (full ? count : count + 1'b1);

    always_ff @(posedge i_serial_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift <= '0;
            count <= '0;
        end else begin
            shift <= next_shift;
            count <= next_count;
        end
    end

    assign link.word = shift;
    assign link.word_full = full;

endmodule : pllps_serial_shift

`default_nettype wire

/* File: test/pllps_assertions.sv */
`include "pllps_consts.svh"
`default_nettype none
module pllps_assertions #(
    parameter int WAKE_CYCLES = `PLLPS_WAKE_CYCLES,
    parameter int PULSE_LIMIT = `PLLPS_PULSE_LIMIT
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_tristate_control_input,
    input wire logic i_power_save_input,
    input wire logic i_pd_up,
    input wire logic i_pd_down,
    input wire logic i_lock_raw,
    input wire logic i_load_strobe,
    input wire logic o_cp_out,
    input wire logic o_cp_oe,
    input wire logic o_lock_indicator,
    input wire logic o_power_saving,
    input wire logic [`PLLPS_PAYLOAD_BITS-1:0] o_ref_word,
    input wire logic o_ref_load,
    input wire logic o_main_load
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Cycles since leaving standby, and run length of the pump enable.
    // ----
    int wake_cnt;
    int run;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wake_cnt <= 0;
            run <= 0;
        end else begin
            wake_cnt <= o_power_saving ? 0 : wake_cnt + 1;
            run <= o_cp_oe ? run + 1 : 0;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence ps_low; !i_power_save_input [*5]; endsequence
    sequence ps_high; i_power_save_input [*5]; endsequence
    wire saving2 = o_power_saving && o_lock_indicator;
    a_save_on_low: assert property (ps_low |-> o_power_saving)
        else $error("power saving not entered");
    a_save_off_high: assert property (ps_high |-> !o_power_saving)
        else $error("power saving not left");
    a_hiz_saving: assert property (o_power_saving && $past(o_power_saving) |-> !o_cp_oe)
        else $error("pump driven in power saving");
    a_lock_saving: assert property (o_power_saving && $past(o_power_saving) |-> saving2)
        else $error("lock low in power saving");
    a_lock_normal: assert property (!o_power_saving && !$past(o_power_saving)
        |-> o_lock_indicator == $past(i_lock_raw))
        else $error("lock does not follow detector");
    a_hiz_tristate: assert property (!i_tristate_control_input [*4] |=> !o_cp_oe)
        else $error("pump driven with tristate low");
    a_drive_error: assert property (o_cp_oe |-> $past(i_pd_up ^ i_pd_down)
        && o_cp_out == $past(i_pd_up))
        else $error("pump drive wrong");
    a_wake_limit: assert property (wake_cnt > 0 && wake_cnt < WAKE_CYCLES && o_cp_oe
        |-> run < PULSE_LIMIT)
        else $error("wake pulse too long");
    a_load_pulse: assert property (o_ref_load || o_main_load
        |-> !(o_ref_load && o_main_load) ##1 !(o_ref_load || o_main_load))
        else $error("bad load pulse");
    a_load_strobe: assert property (o_ref_load || o_main_load
        |-> i_load_strobe && $past(i_load_strobe, 2))
        else $error("load without strobe high");
    a_ref_hold: assert property ($changed(o_ref_word) |-> o_ref_load)
        else $error("reference word changed without load");
endmodule : pllps_assertions
bind pllps_top pllps_assertions #(.WAKE_CYCLES(WAKE_CYCLES), .PULSE_LIMIT(PULSE_LIMIT))
    u_pllps_assertions (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_tristate_control_input(i_tristate_control_input),
    .i_power_save_input(i_power_save_input), .i_pd_up(i_pd_up), .i_pd_down(i_pd_down),
    .i_lock_raw(i_lock_raw), .i_load_strobe(i_load_strobe), .o_cp_out(o_cp_out),
    .o_cp_oe(o_cp_oe), .o_lock_indicator(o_lock_indicator), .o_power_saving(o_power_saving),
    .o_ref_word(o_ref_word), .o_ref_load(o_ref_load), .o_main_load(o_main_load));
`default_nettype wire

/* File: test/pllps_host_model.sv */
`default_nettype none
module pllps_host_model (
    output logic o_serial_clock,
    output logic o_serial_data,
    output logic o_load_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Serial clock stands still between frames unless idle_tick pulses it; data is inverted once released.
    // ----
    initial begin
        o_serial_clock = 1'b0;
        o_serial_data = 1'b0;
        o_load_strobe = 1'b1;
    end
    task automatic send_word(input logic [18:0] word, input int nbits);
        #7;
        o_load_strobe = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            o_serial_data = word[i];
            #15 o_serial_clock = 1'b1;
            #15 o_serial_clock = 1'b0;
        end
        #15 o_load_strobe = 1'b1;
        o_serial_data = ~o_serial_data;
    endtask : send_word
    // One serial edge with the strobe high restarts the bit count of the next frame.
    task automatic idle_tick();
        #7 o_serial_clock = 1'b1;
        #15 o_serial_clock = 1'b0;
    endtask : idle_tick
endmodule : pllps_host_model
`default_nettype wire

/* File: test/pllps_top_tb_top.sv */
`default_nettype none
module pllps_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, zc, ps, up, dn, lraw, cp, oe, lock, sav, rl, ml;
    wire sclk, sdat, le;
    logic [17:0] rw, mw;
    int num_errors = 0;
    int compares = 0;
    int rn = 0;
    int mn = 0;
    int k;
    pllps_host_model u_pllps_host_model (.o_serial_clock(sclk), .o_serial_data(sdat),
        .o_load_strobe(le));
    pllps_top #(.WAKE_CYCLES(8), .PULSE_LIMIT(1)) u_pllps_top (.i_clock(clk), .i_rst_n(rst_n),
        .i_serial_clock(sclk), .i_serial_data(sdat), .i_load_strobe(le),
        .i_tristate_control_input(zc), .i_power_save_input(ps), .i_pd_up(up), .i_pd_down(dn),
        .i_lock_raw(lraw), .o_cp_out(cp), .o_cp_oe(oe), .o_lock_indicator(lock),
        .o_power_saving(sav), .o_ref_word(rw), .o_main_word(mw), .o_ref_load(rl),
        .o_main_load(ml));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        rn += rl;
        mn += ml;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #200us;
        num_errors++;
        end_of_test();
    end
    initial begin
        {rst_n, zc, ps, up, dn, lraw} <= 6'b010000;
        cyc(16);
        rst_n <= 1'b1;
        up <= 1'b1;
        cyc(30);
        #1 check("saving", sav, 1);
        check("lock", lock, 1);
        check("oe", oe, 0);
        cyc(1);
        up <= 1'b0;
        ps <= 1'b1;
        cyc(3);
        up <= 1'b1;
        k = 0;
        repeat (8) begin
            cyc(1);
            #1 k += oe;
        end
        check("wake pulses", k, 1);
        cyc(1);
        #1 check("saving", sav, 0);
        check("oe", oe, 1);
        check("out", cp, 1);
        check("lock", lock, 0);
        cyc(1);
        lraw <= 1'b1;
        cyc(2);
        #1 check("lock", lock, 1);
        cyc(1);
        up <= 1'b0;
        dn <= 1'b1;
        zc <= 1'b0;
        lraw <= 1'b0;
        cyc(5);
        #1 check("oe", oe, 0);
        cyc(1);
        zc <= 1'b1;
        cyc(4);
        #1 check("oe", oe, 1);
        check("out", cp, 0);
        u_pllps_host_model.send_word({18'h2a5c3, 1'b1}, 19);
        cyc(8);
        #1 check("ref word", rw, 18'h2a5c3);
        u_pllps_host_model.send_word({18'h15a3c, 1'b0}, 19);
        cyc(8);
        #1 check("main word", mw, 18'h15a3c);
        u_pllps_host_model.idle_tick();
        u_pllps_host_model.send_word({18'h3ffff, 1'b1}, 10);
        cyc(8);
        #1 check("ref loads", rn, 1);
        check("main loads", mn, 1);
        check("ref word kept", rw, 18'h2a5c3);
        cyc(1);
        ps <= 1'b0;
        cyc(5);
        #1 check("saving", sav, 1);
        check("oe", oe, 0);
        check("lock", lock, 1);
        end_of_test();
    end
endmodule : pllps_top_tb_top
`default_nettype wire
